//--- i2c_link_if.sv
// i2c_link_if: the two-wire link between controller and target
// assumes: wires resolved in this interface as open drain with pull-ups
`timescale 1ns/1ps
`default_nettype none
interface i2c_link_if;
	logic scl_o_ctl;
	logic scl_oe_b_ctl;
	logic sda_o_ctl;
	logic sda_oe_b_ctl;
	logic sda_o_tgt;
	logic sda_oe_b_tgt;
	logic scl;
	logic sda;
	// wired-and of the drivers (controller alone on scl, both ends on sda), low only when enabled
	assign scl = !(scl_oe_b_ctl == 1'b0 && scl_o_ctl == 1'b0);
	assign sda = !((sda_oe_b_ctl == 1'b0 && sda_o_ctl == 1'b0) || (sda_oe_b_tgt == 1'b0 && sda_o_tgt == 1'b0));
	modport controller (output scl_o_ctl, scl_oe_b_ctl, sda_o_ctl, sda_oe_b_ctl, input scl, sda);
	modport target (output sda_o_tgt, sda_oe_b_tgt, input scl, sda);
endinterface
`default_nettype wire

//--- i2c_paged_asserts.sv
// i2c_paged_asserts: timing checks on the two-wire link between both ends
// assumes: instantiated beside the link interface, all in the sys_clk domain
`timescale 1ns/1ps
`default_nettype none
module i2c_paged_asserts
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// link drivers and resolved wires
	input wire logic scl_o_ctl,
	input wire logic scl_oe_b_ctl,
	input wire logic sda_o_ctl,
	input wire logic sda_oe_b_ctl,
	input wire logic sda_o_tgt,
	input wire logic sda_oe_b_tgt,
	input wire logic scl,
	input wire logic sda
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);
	////////////////////////////////////////////////////////////////////////////////
	// helper: clock rises seen while the target holds sda low
	logic scl_q;
	logic [3:0] hold_rises;
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			scl_q <= 1'b1;
			hold_rises <= 4'h0;
		end
		else
		begin
			scl_q <= scl;
			if (sda_oe_b_tgt)
				hold_rises <= 4'h0;
			else if (scl && !scl_q)
				hold_rises <= hold_rises + 4'h1;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// properties
	property p_open_drain;
		sda_o_tgt == 1'b0 && sda_o_ctl == 1'b0 && scl_o_ctl == 1'b0;
	endproperty
	property p_tgt_stable;
		scl && $past(scl) |-> $stable(sda_oe_b_tgt);
	endproperty
	property p_min_low;
		$fell(scl) |-> !scl [*8];
	endproperty
	property p_min_high;
		$rose(scl) |-> scl [*8];
	endproperty
	property p_max_low;
		!scl |-> ##[1:400] scl;
	endproperty
	property p_start_clock;
		$fell(sda) && scl |-> ##[1:400] !scl;
	endproperty
	property p_tgt_not_start;
		$fell(sda) && scl && $past(scl) |-> sda_oe_b_tgt && $past(sda_oe_b_tgt);
	endproperty
	property p_tgt_hold;
		hold_rises <= 4'h9;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("line driven high");
	a_tgt_stable: assert property (p_tgt_stable) else $error("target moved sda with scl high");
	a_min_low: assert property (p_min_low) else $error("scl low too short");
	a_min_high: assert property (p_min_high) else $error("scl high too short");
	a_max_low: assert property (p_max_low) else $error("scl low too long");
	a_start_clock: assert property (p_start_clock) else $error("no clock after start");
	a_tgt_not_start: assert property (p_tgt_not_start) else $error("target made a start");
	a_tgt_hold: assert property (p_tgt_hold) else $error("target held sda too long");
	// main scenarios
	c_start: cover property ($fell(sda) && scl);
	c_ack: cover property ($fell(sda_oe_b_tgt));
	c_stop: cover property ($rose(sda) && scl);
endmodule
`default_nettype wire

//--- i2c_paged_control_port_bench.sv
// i2c_paged_control_port_bench: controller and target joined over the link
// assumes: controller register port drives the link, target outputs observed
`timescale 1ns/1ps
`default_nettype none
module i2c_paged_control_port_bench
	import i2c_paged_pkg::*;
;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [1:0] addr = 2'h0;
	logic [1:0] addr_strap = 2'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata, book_sel, page_sel, crc_sum, xor_sum;
	logic write_pulse;
	int n_errors = 0;
	int compares = 0;
	int n_pulses = 0;
	// 40 MHz clock
	always #12.5 sys_clk = ~sys_clk;
	////////////////////////////////////////////////////////////////////////////////
	// both ends and the checker
	i2c_link_if link();
	i2c_paged_target #(.PAGES(4)) i2c_paged_target_i (.sys_clk(sys_clk), .rst_b(rst_b), .link(link),
		.addr_strap(addr_strap), .book_sel(book_sel), .page_sel(page_sel), .crc_sum(crc_sum),
		.xor_sum(xor_sum), .write_pulse(write_pulse));
	i2c_paged_controller i2c_paged_controller_i (.sys_clk(sys_clk), .rst_b(rst_b), .link(link),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
	i2c_paged_asserts i2c_paged_asserts_i (.sys_clk(sys_clk), .rst_b(rst_b), .scl_o_ctl(link.scl_o_ctl),
		.scl_oe_b_ctl(link.scl_oe_b_ctl), .sda_o_ctl(link.sda_o_ctl), .sda_oe_b_ctl(link.sda_oe_b_ctl),
		.sda_o_tgt(link.sda_o_tgt), .sda_oe_b_tgt(link.sda_oe_b_tgt), .scl(link.scl), .sda(link.sda));
	// count written data bytes
	always @(posedge sys_clk)
		if (write_pulse === 1'b1)
			n_pulses++;
	////////////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic [7:0] crc_ref(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		repeat (8)
			r = r[7] ? {r[6:0], 1'b0} ^ 8'h07 : {r[6:0], 1'b0};
		return r;
	endfunction
	task check(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp)
		begin
			$display("wrong value %s expected %h seen %h", what, exp, got);
			n_errors++;
		end
	endtask
	task reg_wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask
	task reg_rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	// one transaction, then poll until idle
	task xfer(input logic [7:0] dev, input logic [7:0] sub, input logic [7:0] d, output logic [7:0] st);
		int n;
		reg_wr(2'h0, dev);
		reg_wr(2'h1, sub);
		reg_wr(2'h2, d);
		n = 0;
		st = 8'h02;
		while (st[1] !== 1'b0 && n < 20000)
		begin
			reg_rd(2'h3, st);
			n++;
		end
		check("busy", 8'h00, {7'h00, st[1]});
	endtask
	task wr8(input logic [7:0] sub, input logic [7:0] d);
		logic [7:0] st;
		xfer({ADDR_FIXED, addr_strap, 1'b0}, sub, d, st);
		check("write ack", 8'h00, {7'h00, st[2]});
	endtask
	task rd8(input logic [7:0] sub, output logic [7:0] d);
		logic [7:0] st;
		xfer({ADDR_FIXED, addr_strap, 1'b1}, sub, 8'h00, st);
		check("read ack", 8'h00, {7'h00, st[2]});
		reg_rd(2'h2, d);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// scenarios
	task t_strap;
		logic [7:0] st;
		int p;
		for (int i = 0; i < 4; i++)
		begin
			reg_wr(2'h3, (i == 0) ? 8'h00 : 8'h01);
			addr_strap <= i[1:0];
			p = n_pulses;
			xfer({ADDR_FIXED, i[1:0], 1'b0}, REG_PAGE, 8'(i + 1), st);
			check("strap ack", 8'h00, {7'h00, st[2]});
			check("page", 8'(i + 1), page_sel);
			xfer({ADDR_FIXED, i[1:0] ^ 2'h1, 1'b0}, REG_PAGE, 8'h55, st);
			check("other address nack", 8'h01, {7'h00, st[2]});
			check("page kept", 8'(i + 1), page_sel);
			check("pulses", 8'h01, 8'(n_pulses - p));
		end
	endtask
	task t_checksum;
		logic [7:0] crc, d;
		int p;
		wr8(REG_PAGE, PAGE_ZERO);
		wr8(REG_BOOK, BOOK_XOR);
		check("book", BOOK_XOR, book_sel);
		wr8(REG_XOR, CLEAR_VALUE);
		wr8(REG_CRC, CLEAR_VALUE);
		check("crc clear", 8'h00, crc_sum);
		check("xor clear", 8'h00, xor_sum);
		wr8(REG_PAGE, 8'h01);
		wr8(8'h10, 8'hA5);
		wr8(8'h11, 8'h3C);
		crc = crc_ref(crc_ref(8'h00, 8'hA5), 8'h3C);
		check("crc", crc, crc_sum);
		check("xor", 8'h99, xor_sum);
		rd8(8'h10, d);
		check("read data", 8'hA5, d);
		check("crc after read", crc, crc_sum);
		check("xor after read", 8'h99, xor_sum);
		wr8(REG_PAGE, PAGE_ZERO);
		wr8(8'h20, 8'h5A);
		crc = crc_ref(crc, 8'h5A);
		rd8(REG_CRC, d);
		check("crc read", crc, d);
		rd8(REG_XOR, d);
		check("xor read", 8'h99, d);
		// one complete filter group in the coefficient book
		wr8(REG_BOOK, BOOK_FILTER);
		check("filter book", BOOK_FILTER, book_sel);
		p = n_pulses;
		for (int k = 0; k < 5; k++)
		begin
			wr8(8'h18 + 8'(k), 8'h11 * 8'(k + 1));
			crc = crc_ref(crc, 8'h11 * 8'(k + 1));
		end
		check("filter crc", crc, crc_sum);
		check("filter xor", 8'h99, xor_sum);
		check("filter pulses", 8'h05, 8'(n_pulses - p));
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// verdict and end of run
	task conclude;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// main sequence
	initial
	begin
		repeat (6) @(posedge sys_clk);
		rst_b <= 1'b1;
		t_strap();
		t_checksum();
		conclude();
	end
	// watchdog
	initial
	begin
		#2500000;
		n_errors++;
		conclude();
	end
endmodule
`default_nettype wire

//--- i2c_paged_controller.sv
// i2c_paged_controller: bus controller issuing register writes and reads
// assumes: one command at a time from a plain register port
`timescale 1ns/1ps
`default_nettype none
module i2c_paged_controller
	import i2c_paged_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// link
	i2c_link_if.controller link,
	// register port
	input wire logic [1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata
);
	// reg 0 target, reg 1 sub-address, reg 2 data / go, reg 3 status
	localparam logic [1:0] C_TGT = 2'h0;
	localparam logic [1:0] C_SUB = 2'h1;
	localparam logic [1:0] C_DATA = 2'h2;
	localparam logic [1:0] C_STAT = 2'h3;
	typedef enum logic [2:0] {C_IDLE, C_START, C_BYTE, C_GETACK, C_RESTART, C_READ, C_STOP} cst_t;
	typedef struct packed {
		cst_t st;
		logic [7:0] tgt;
		logic [7:0] sub;
		logic [7:0] data;
		logic [7:0] sh;
		logic [2:0] phase;
		logic [1:0] q;
		logic [9:0] div;
		logic [3:0] bits;
		logic fast;
		logic read;
		logic nack;
		logic [7:0] rdata;
		logic scl_low;
		logic sda_low;
		logic [1:0] sda_sync;
	} cst_s_t;
	cst_s_t s_reg;
	cst_s_t s_next;

	always_comb
	begin
		logic tick;
		tick = s_reg.div >= (s_reg.fast ? 10'(QTR_FAST - 1) : 10'(QTR_STD - 1));
		s_next = s_reg;
		// data line through two flops before any sampling
		s_next.sda_sync = {s_reg.sda_sync[0], link.sda};
		// register writes
		if (wr && addr == C_TGT)
			s_next.tgt = wdata;
		else if (wr && addr == C_SUB)
			s_next.sub = wdata;
		else if (wr && addr == C_STAT)
			s_next.fast = wdata[0];
		else if (wr && addr == C_DATA && s_reg.st == C_IDLE)
		begin
			s_next.data = wdata;
			s_next.read = s_reg.tgt[0];
			s_next.st = C_START;
			s_next.phase = 3'h0;
			s_next.nack = 1'b0;
		end
		s_next.div = tick ? 10'h000 : s_reg.div + 10'h001;
		if (tick && s_reg.st != C_IDLE)
		begin
			s_next.q = s_reg.q + 2'h1;
			case (s_reg.st)
				C_START, C_RESTART:
				begin
					// sda falls while scl high
					if (s_reg.q == 2'h0)
					begin
						s_next.sda_low = 1'b0;
						s_next.scl_low = 1'b0;
					end
					if (s_reg.q == 2'h2) s_next.sda_low = 1'b1;
					if (s_reg.q == 2'h3)
					begin
						s_next.scl_low = 1'b1;
						s_next.st = C_BYTE;
						s_next.bits = 4'h0;
						s_next.sh = s_reg.st == C_RESTART ? {s_reg.tgt[7:1], 1'b1} : {s_reg.tgt[7:1], 1'b0};
					end
				end
				C_BYTE, C_READ:
				begin
					if (s_reg.q == 2'h0)
						s_next.sda_low = s_reg.st == C_READ ? (s_reg.bits == 4'h8 && s_reg.phase != 3'h3) : !s_reg.sh[7];
					if (s_reg.q == 2'h1) s_next.scl_low = 1'b0;
					if (s_reg.q == 2'h2 && s_reg.st == C_READ && s_reg.bits != 4'h8)
						s_next.rdata = {s_reg.rdata[6:0], s_reg.sda_sync[1]};
					if (s_reg.q == 2'h3)
					begin
						s_next.scl_low = 1'b1;
						s_next.sh = {s_reg.sh[6:0], 1'b0};
						s_next.bits = s_reg.bits + 4'h1;
						if (s_reg.st == C_BYTE && s_reg.bits == 4'h7)
							s_next.st = C_GETACK;
						else if (s_reg.st == C_READ && s_reg.bits == 4'h8)
							s_next.st = C_STOP;
					end
				end
				C_GETACK:
				begin
					if (s_reg.q == 2'h0) s_next.sda_low = 1'b0;
					if (s_reg.q == 2'h1) s_next.scl_low = 1'b0;
					if (s_reg.q == 2'h2) s_next.nack = s_reg.sda_sync[1];
					if (s_reg.q == 2'h3)
					begin
						s_next.scl_low = 1'b1;
						s_next.bits = 4'h0;
						s_next.phase = s_reg.phase + 3'h1;
						if (s_reg.nack)
							s_next.st = C_STOP;
						else if (s_reg.phase == 3'h0)
						begin
							s_next.st = C_BYTE;
							s_next.sh = s_reg.sub;
						end
						else if (s_reg.phase == 3'h1)
						begin
							s_next.st = s_reg.read ? C_RESTART : C_BYTE;
							s_next.sh = s_reg.data;
						end
						else if (s_reg.phase == 3'h2 && s_reg.read)
						begin
							s_next.st = C_READ;
							s_next.phase = 3'h3;
						end
						else
							s_next.st = C_STOP;
					end
				end
				default:
				begin
					// stop: sda rises while scl high
					if (s_reg.q == 2'h0) s_next.sda_low = 1'b1;
					if (s_reg.q == 2'h1) s_next.scl_low = 1'b0;
					if (s_reg.q == 2'h2) s_next.sda_low = 1'b0;
					if (s_reg.q == 2'h3) s_next.st = C_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register and read port
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s_reg <= '{st: C_IDLE, sda_sync: 2'b11, default: '0};
			rdata <= 8'h00;
		end
		else
		begin
			s_reg <= s_next;
			if (rd && addr == C_STAT)
				rdata <= {5'h00, s_reg.nack, s_reg.st != C_IDLE, s_reg.fast};
			else if (rd && addr == C_DATA)
				rdata <= s_reg.rdata;
			else if (rd)
				rdata <= addr == C_TGT ? s_reg.tgt : s_reg.sub;
			else
				rdata <= 8'h00;
		end
	end

	assign link.scl_o_ctl = 1'b0;
	assign link.scl_oe_b_ctl = !s_reg.scl_low;
	assign link.sda_o_ctl = 1'b0;
	assign link.sda_oe_b_ctl = !s_reg.sda_low;
endmodule
`default_nettype wire

//--- i2c_paged_pkg.sv
// i2c_paged_pkg: constants, register map and types shared by both ends
// assumes: both ends run on sys_clk at 40 MHz, the link clock is sampled
`default_nettype none
package i2c_paged_pkg;
	localparam logic [4:0] ADDR_FIXED = 5'h13;
	localparam logic [7:0] REG_PAGE = 8'h00;
	localparam logic [7:0] REG_XOR = 8'h7D;
	localparam logic [7:0] REG_CRC = 8'h7E;
	localparam logic [7:0] REG_BOOK = 8'h7F;
	localparam logic [7:0] PAGE_ZERO = 8'h00;
	localparam logic [7:0] BOOK_XOR = 8'h8C;
	localparam logic [7:0] BOOK_FILTER = 8'hAA;
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CLEAR_VALUE = 8'h00;
	localparam int SYS_HZ = 40000000;
	localparam int SCL_STD_HZ = 100000;
	localparam int SCL_FAST_HZ = 400000;
	// quarter bit period of the controller's clock divider
	localparam int QTR_STD = SYS_HZ / (4 * SCL_STD_HZ);
	localparam int QTR_FAST = SYS_HZ / (4 * SCL_FAST_HZ);
	localparam int MEM_BOOKS = 4;
	typedef enum logic [1:0] {STRAP_GND, STRAP_1K, STRAP_4K7, STRAP_15K} strap_t;
	// one crc step over a full byte
	function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] data);
		logic [7:0] c;
		c = crc ^ data;
		for (int i = 0; i < 8; i++)
		begin
			c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
		end
		return c;
	endfunction
endpackage
`default_nettype wire

//--- i2c_paged_target.sv
// i2c_paged_target: serial control port with book/page map and checksums
// assumes: scl and sda come from another domain and are synchronised here
`timescale 1ns/1ps
`default_nettype none
module i2c_paged_target
	import i2c_paged_pkg::*;
#(
	parameter int PAGES = 4
)
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// link
	i2c_link_if.target link,
	// strap decoded from the address resistor
	input wire logic [1:0] addr_strap,
	// status seen by the device core
	output logic [7:0] book_sel,
	output logic [7:0] page_sel,
	output logic [7:0] crc_sum,
	output logic [7:0] xor_sum,
	output logic write_pulse
);
	typedef enum logic [2:0] {T_IDLE, T_ADDR, T_REG, T_WDATA, T_RDATA, T_ACK, T_RACK, T_IGNORE} tstate_t;
	typedef struct packed {
		logic [1:0] scl_sync;
		logic [1:0] sda_sync;
		logic scl_prev;
		logic sda_prev;
		logic [1:0] strap;
		logic [3:0] strap_sync;
		tstate_t st;
		tstate_t after_ack;
		logic [3:0] bitcnt;
		logic [7:0] shift;
		logic [7:0] sub;
		logic [7:0] book;
		logic [7:0] page;
		logic [7:0] crc;
		logic [7:0] xsum;
		logic sda_low;
		logic wr;
	} tstate_s_t;
	localparam int MEM_WORDS = MEM_BOOKS * PAGES * 256;
	localparam int MW = $clog2(MEM_WORDS);
	logic [7:0] mem [MEM_WORDS];
	tstate_s_t s_reg;
	tstate_s_t s_next;
	logic mem_we;
	logic [MW-1:0] mem_addr;
	logic [7:0] mem_rd;

	// flat index of book, page and sub-address into the backing store
	function automatic logic [MW-1:0] map_addr(input logic [7:0] b, input logic [7:0] p, input logic [7:0] r);
		logic [31:0] idx;
		idx = ((32'(b) % MEM_BOOKS) * PAGES + (32'(p) % PAGES)) * 256 + 32'(r);
		return idx[MW-1:0];
	endfunction

	// read value with the special registers folded in
	function automatic logic [7:0] reg_read(input tstate_s_t s, input logic [7:0] m);
		logic [7:0] v;
		v = m;
		if (s.sub == REG_PAGE)
			v = s.page;
		else if (s.page == PAGE_ZERO && s.sub == REG_BOOK)
			v = s.book;
		else if (s.page == PAGE_ZERO && s.sub == REG_CRC)
			v = s.crc;
		else if (s.page == PAGE_ZERO && s.book == BOOK_XOR && s.sub == REG_XOR)
			v = s.xsum;
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// next state of the whole target
	always_comb
	begin
		logic scl_rise;
		logic scl_fall;
		logic start_c;
		logic stop_c;
		logic [7:0] b;
		logic sel_wr;
		logic [7:0] rv;
		rv = 8'h00;
		scl_rise = 1'b0;
		scl_fall = 1'b0;
		start_c = 1'b0;
		stop_c = 1'b0;
		b = 8'h00;
		sel_wr = 1'b0;
		s_next = s_reg;
		s_next.wr = 1'b0;
		mem_we = 1'b0;
		s_next.scl_sync = {s_reg.scl_sync[0], link.scl};
		s_next.sda_sync = {s_reg.sda_sync[0], link.sda};
		s_next.scl_prev = s_reg.scl_sync[1];
		s_next.sda_prev = s_reg.sda_sync[1];
		// strap pin through two flops, latched only between transactions
		s_next.strap_sync = {s_reg.strap_sync[1:0], addr_strap};
		if (s_reg.st == T_IDLE)
			s_next.strap = s_reg.strap_sync[3:2];
		scl_rise = s_reg.scl_sync[1] && !s_reg.scl_prev;
		scl_fall = !s_reg.scl_sync[1] && s_reg.scl_prev;
		start_c = s_reg.scl_sync[1] && s_reg.scl_prev && s_reg.sda_prev && !s_reg.sda_sync[1];
		stop_c = s_reg.scl_sync[1] && s_reg.scl_prev && !s_reg.sda_prev && s_reg.sda_sync[1];
		b = {s_reg.shift[6:0], s_reg.sda_sync[1]};
		if (start_c)
		begin
			s_next.st = T_ADDR;
			s_next.bitcnt = 4'h0;
			s_next.sda_low = 1'b0;
		end
		else if (stop_c)
		begin
			s_next.st = T_IDLE;
			s_next.sda_low = 1'b0;
		end
		else
		begin
			case (s_reg.st)
				T_ADDR, T_REG, T_WDATA:
				begin
					if (scl_rise)
					begin
						s_next.shift = b;
						s_next.bitcnt = s_reg.bitcnt + 4'h1;
					end
					if (scl_fall && s_reg.bitcnt == 4'h8)
					begin
						s_next.bitcnt = 4'h0;
						s_next.st = T_ACK;
						s_next.sda_low = 1'b1;
						if (s_reg.st == T_ADDR)
						begin
							if (s_reg.shift[7:1] != {ADDR_FIXED, s_reg.strap})
							begin
								s_next.st = T_IGNORE;
								s_next.sda_low = 1'b0;
							end
							else
								s_next.after_ack = s_reg.shift[0] ? T_RDATA : T_REG;
						end
						else if (s_reg.st == T_REG)
						begin
							s_next.sub = s_reg.shift;
							s_next.after_ack = T_WDATA;
						end
						else
						begin
							// a write lands; page/book selects and a crc clear skip the crc, xor only counts in BOOK_XOR off page zero
							s_next.wr = 1'b1;
							mem_we = 1'b1;
							sel_wr = s_reg.sub == REG_PAGE || (s_reg.page == PAGE_ZERO && s_reg.sub == REG_BOOK);
							if (s_reg.sub == REG_PAGE)
								s_next.page = s_reg.shift;
							else if (s_reg.page == PAGE_ZERO && s_reg.sub == REG_BOOK)
								s_next.book = s_reg.shift;
							if (s_reg.page == PAGE_ZERO && s_reg.sub == REG_CRC && s_reg.shift == CLEAR_VALUE)
								s_next.crc = CLEAR_VALUE;
							else if (!sel_wr)
								s_next.crc = crc8_step(s_reg.crc, s_reg.shift);
							if (s_reg.book == BOOK_XOR && s_reg.page == PAGE_ZERO && s_reg.sub == REG_XOR
								&& s_reg.shift == CLEAR_VALUE)
								s_next.xsum = CLEAR_VALUE;
							else if (s_reg.book == BOOK_XOR && s_reg.page != PAGE_ZERO && !sel_wr)
								s_next.xsum = s_reg.xsum ^ s_reg.shift;
							s_next.sub = s_reg.sub + 8'h01;
							s_next.after_ack = T_WDATA;
						end
					end
				end
				T_ACK:
				begin
					// release after the ninth clock, then shift on
					if (scl_fall)
					begin
						s_next.sda_low = 1'b0;
						s_next.st = s_reg.after_ack;
						if (s_reg.after_ack == T_RDATA)
						begin
							rv = reg_read(s_reg, mem_rd);
							s_next.shift = rv;
							s_next.sda_low = !rv[7];
							s_next.bitcnt = 4'h1;
							s_next.sub = s_reg.sub + 8'h01;
						end
					end
				end
				T_RDATA:
				begin
					if (scl_fall)
					begin
						if (s_reg.bitcnt == 4'h8)
						begin
							s_next.sda_low = 1'b0;
							s_next.st = T_RACK;
						end
						else
						begin
							s_next.shift = {s_reg.shift[6:0], 1'b0};
							s_next.sda_low = !s_reg.shift[6];
							s_next.bitcnt = s_reg.bitcnt + 4'h1;
						end
					end
				end
				T_RACK:
				begin
					// controller ack continues, nack ends the read
					if (scl_rise)
						s_next.st = s_reg.sda_sync[1] ? T_IGNORE : T_ACK;
					s_next.after_ack = T_RDATA;
				end
				default:
				begin
					s_next.sda_low = 1'b0;
				end
			endcase
		end
	end

	assign mem_addr = map_addr(s_reg.book, s_reg.page, s_reg.sub);
	assign mem_rd = mem[mem_addr];

	////////////////////////////////////////////////////////////////////////
	// state and backing store
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s_reg <= '{st: T_IDLE, after_ack: T_IDLE, scl_sync: 2'b11, sda_sync: 2'b11,
				scl_prev: 1'b1, sda_prev: 1'b1, default: '0};
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (mem_we)
			mem[mem_addr] <= s_reg.shift;
	end

	assign link.sda_o_tgt = 1'b0;
	assign link.sda_oe_b_tgt = !s_reg.sda_low;
	assign book_sel = s_reg.book;
	assign page_sel = s_reg.page;
	assign crc_sum = s_reg.crc;
	assign xor_sum = s_reg.xsum;
	assign write_pulse = s_reg.wr;
endmodule
`default_nettype wire
